// ---- src/flash_cmd_pkg.sv ----
package flash_cmd_pkg;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PROTECT_SECTOR = 8'h36;
  localparam logic [7:0] OP_UNPROTECT_SECTOR = 8'h39;
  localparam int SECTOR_COUNT = 16;
  localparam int SECTOR_SEL_LSB = 16;
  localparam int SECTOR_SEL_W = 4;
  localparam int ADDR_W = 24;
  localparam int ADDR_BYTES = 3;
  localparam logic [SECTOR_COUNT-1:0] PROTECT_RESET = 16'hffff;
  localparam int CLK_PERIOD_PS = 5000;
  // default erase time, arbitrary plain figure in microseconds
  localparam int CHIP_ERASE_DURATION_US = 1000;
  localparam int CHIP_ERASE_CYCLES = (CHIP_ERASE_DURATION_US * 1000000) / CLK_PERIOD_PS;
endpackage

// ---- src/flash_erase_protect_cmds.sv ----
// Behaviour
// - chip erase runs only when the write latch was already set.
// - opcodes 60h and c7h both start the same chip erase.
// - chip erase ignores trailing bytes and starts at chip select release.
// - release off a byte boundary or before full opcode: no erase.
// - any protected or locked sector refuses chip erase, back to idle.
// - refused chip erase clears the write latch.
// - busy during erase; write latch cleared before erase ends.
// - failed erase verify sets the erase/program fail flag.
// - write enable 06h sets the latch at release, extra bytes ignored.
// - protect, unprotect and erase need the write latch set.
// - bad write enable/disable framing leaves the latch unchanged.
// - write disable 04h clears the latch at release.
// - one protect bit per 64-Kbyte sector, all set at reset.
// - bit 0 allows erase of the sector, bit 1 blocks it.
// - protect sector with full address sets bit, clears latch.
// - short or misaligned protect sector: bit kept, latch cleared.
// - lock bit set: protect/unprotect ignored, latch cleared.
// - unprotect sector with full address clears bit, clears latch.
// - short or misaligned unprotect sector: bit kept, latch cleared.
// - sector chosen by bits 19:16 of the 24-bit address.
`timescale 1ns/1ps
module flash_erase_protect_cmds #(
  parameter int ERASE_CYCLES = flash_cmd_pkg::CHIP_ERASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic spi_sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic protect_regs_lock_bit,
  input wire logic [flash_cmd_pkg::SECTOR_COUNT-1:0] sector_locked,
  input wire logic erase_verify_fail,
  output logic write_latch_flag,
  output logic busy,
  output logic erase_program_fail_flag,
  output logic erase_start,
  output logic [flash_cmd_pkg::SECTOR_COUNT-1:0] sector_protect_bit
);

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_CHECK} state_t;

  function automatic logic is_chip_erase(input logic [7:0] op);
    is_chip_erase = (op == flash_cmd_pkg::OP_CHIP_ERASE_A) || (op == flash_cmd_pkg::OP_CHIP_ERASE_B);
  endfunction

  // link side: counters restart from zero at the first clock after chip select falls
  logic [2:0] bit_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] opcode_q;
  logic [flash_cmd_pkg::ADDR_W-1:0] addr_q;
  logic [7:0] byte_in;

  assign byte_in = {shift_q, mosi};

  logic in_frame_q;
  logic [2:0] bit_pos;
  logic [2:0] byte_pos;

  // drops as chip select rises; counts then hold for the core side to judge
  always_ff @(posedge spi_sck or posedge cs_n or negedge arst_n) begin
    if (!arst_n) begin
      in_frame_q <= 1'b0;
    end else if (cs_n) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end

  assign bit_pos = in_frame_q ? bit_cnt_q : 3'h0;
  assign byte_pos = in_frame_q ? byte_cnt_q : 3'h0;

  always_ff @(posedge spi_sck or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_pos + 3'h1;
      if (bit_pos == 3'h7 && byte_pos != 3'h4) begin
        byte_cnt_q <= byte_pos + 3'h1;
      end else begin
        byte_cnt_q <= byte_pos;
      end
    end
  end

  always_ff @(posedge spi_sck or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= 7'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end else begin
      shift_q <= byte_in[6:0];
      if (bit_pos == 3'h7) begin
        if (byte_pos == 3'h0) begin
          opcode_q <= byte_in;
        end else if (byte_pos <= 3'(flash_cmd_pkg::ADDR_BYTES)) begin
          addr_q <= {addr_q[15:0], byte_in};
        end
      end
    end
  end

  // core side: three-stage synchronisers
  logic [2:0] cs_sync_q;
  logic cs_high_q;
  logic [2:0] fail_sync_q;
  logic fail_level_q;
  logic [2:0] lock_sync_q;
  logic lock_level_q;
  logic [flash_cmd_pkg::SECTOR_COUNT-1:0] locked_sync_q [3];
  logic [flash_cmd_pkg::SECTOR_COUNT-1:0] locked_level_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync_q <= 3'b111;
      cs_high_q <= 1'b1;
      fail_sync_q <= 3'b000;
      fail_level_q <= 1'b0;
      lock_sync_q <= 3'b000;
      lock_level_q <= 1'b0;
      locked_sync_q[0] <= 16'h0000;
      locked_sync_q[1] <= 16'h0000;
      locked_sync_q[2] <= 16'h0000;
      locked_level_q <= 16'h0000;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
      fail_sync_q <= {fail_sync_q[1:0], erase_verify_fail};
      lock_sync_q <= {lock_sync_q[1:0], protect_regs_lock_bit};
      if (lock_sync_q[1] == lock_sync_q[2]) begin
        lock_level_q <= lock_sync_q[2];
      end
      locked_sync_q[0] <= sector_locked;
      locked_sync_q[1] <= locked_sync_q[0];
      locked_sync_q[2] <= locked_sync_q[1];
      for (int i = 0; i < flash_cmd_pkg::SECTOR_COUNT; i++) begin
        if (locked_sync_q[1][i] == locked_sync_q[2][i]) begin
          locked_level_q[i] <= locked_sync_q[2][i];
        end
      end
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_high_q <= cs_sync_q[2];
      end
      if (fail_sync_q[1] == fail_sync_q[2]) begin
        fail_level_q <= fail_sync_q[2];
      end
    end
  end

  // link registers are frozen while chip select is high, so safe to read here
  logic frame_end;
  logic aligned;
  logic addr_full;
  logic [flash_cmd_pkg::SECTOR_SEL_W-1:0] sector_sel;
  logic any_protected;
  logic is_sector_cmd;

  assign frame_end = cs_sync_q[2] && cs_sync_q[1] && !cs_high_q;
  assign aligned = (bit_cnt_q == 3'h0) && (byte_cnt_q != 3'h0);
  assign addr_full = byte_cnt_q > 3'(flash_cmd_pkg::ADDR_BYTES);
  assign sector_sel = addr_q[flash_cmd_pkg::SECTOR_SEL_LSB +: flash_cmd_pkg::SECTOR_SEL_W];
  assign any_protected = |(sector_protect_bit | locked_level_q);
  assign is_sector_cmd = (opcode_q == flash_cmd_pkg::OP_PROTECT_SECTOR) ||
                         (opcode_q == flash_cmd_pkg::OP_UNPROTECT_SECTOR);

  state_t state_q;
  logic [31:0] erase_cnt_q;
  logic erase_go;

  assign erase_go = frame_end && state_q == ST_IDLE && aligned && is_chip_erase(opcode_q) &&
                    write_latch_flag && !any_protected;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      erase_cnt_q <= 32'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (erase_go) begin
            state_q <= ST_ERASE;
            erase_cnt_q <= 32'(ERASE_CYCLES - 1);
          end
        end
        ST_ERASE: begin
          if (erase_cnt_q == 32'h0) begin
            state_q <= ST_CHECK;
          end else begin
            erase_cnt_q <= erase_cnt_q - 32'h1;
          end
        end
        ST_CHECK: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      erase_start <= 1'b0;
    end else begin
      erase_start <= erase_go;
      busy <= erase_go || (state_q == ST_ERASE);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      erase_program_fail_flag <= 1'b0;
    end else if (state_q == ST_CHECK && fail_level_q) begin
      erase_program_fail_flag <= 1'b1;
    end else if (erase_go) begin
      erase_program_fail_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      write_latch_flag <= 1'b0;
    end else if (frame_end && state_q == ST_IDLE) begin
      if (opcode_q == flash_cmd_pkg::OP_WRITE_ENABLE && aligned) begin
        write_latch_flag <= 1'b1;
      end else if (opcode_q == flash_cmd_pkg::OP_WRITE_DISABLE && aligned) begin
        write_latch_flag <= 1'b0;
      end else if (is_chip_erase(opcode_q) && byte_cnt_q != 3'h0) begin
        write_latch_flag <= 1'b0;
      end else if (is_sector_cmd && byte_cnt_q != 3'h0) begin
        write_latch_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sector_protect_bit <= flash_cmd_pkg::PROTECT_RESET;
    end else if (frame_end && state_q == ST_IDLE && is_sector_cmd && aligned && addr_full &&
                 write_latch_flag && !lock_level_q) begin
      sector_protect_bit[sector_sel] <= (opcode_q == flash_cmd_pkg::OP_PROTECT_SECTOR);
    end
  end

endmodule // flash_erase_protect_cmds

// ---- tb/flash_cmd_monitor.sv ----
`timescale 1ns/1ps
module flash_cmd_monitor #(
  parameter int ERASE_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic spi_sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic protect_regs_lock_bit,
  input wire logic [15:0] sector_locked,
  input wire logic erase_verify_fail,
  input wire logic write_latch_flag,
  input wire logic busy,
  input wire logic erase_program_fail_flag,
  input wire logic erase_start,
  input wire logic [15:0] sector_protect_bit
);
  localparam int E = ERASE_CYCLES;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_erase_run;
    busy ##E busy ##1 !busy;
  endsequence
  a_erase_length: assert property (erase_start |-> s_erase_run)
    else $error("busy length wrong");
  a_erase_latch: assert property (erase_start |-> !write_latch_flag)
    else $error("latch kept at erase start");
  a_start_pulse: assert property (erase_start |=> !erase_start)
    else $error("start pulse too long");
  a_busy_cause: assert property ($rose(busy) |-> erase_start)
    else $error("busy without start");
  a_erase_allowed: assert property (erase_start |-> $past(write_latch_flag) &&
    $past(sector_protect_bit) == 16'h0000 && $past(sector_locked) == 16'h0000) else $error("erase not allowed");
  a_protect_cause: assert property ($changed(sector_protect_bit) |-> $past(write_latch_flag) &&
    !write_latch_flag && !$past(protect_regs_lock_bit)) else $error("protect change wrong");
  a_fail_time: assert property ($rose(erase_program_fail_flag) |-> $past(busy) && !busy)
    else $error("fail flag timing");
  a_wren_idle: assert property ($rose(write_latch_flag) |-> !busy)
    else $error("latch set while busy");
endmodule // flash_cmd_monitor
bind flash_erase_protect_cmds flash_cmd_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) mon_u (.core_clk, .arst_n,
  .spi_sck, .cs_n, .mosi, .protect_regs_lock_bit, .sector_locked, .erase_verify_fail, .write_latch_flag,
  .busy, .erase_program_fail_flag, .erase_start, .sector_protect_bit);

// ---- tb/spi_host.sv ----
`timescale 1ns/1ps
module spi_host (
  output logic spi_sck,
  output logic cs_n,
  output logic mosi
);
  initial begin
    spi_sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // left-aligned frame of n bits; sck idles low outside frames
  task automatic send(input logic [39:0] d, input int n);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = d[39-i];
      #62.5 spi_sck = 1'b1;
      #62.5 spi_sck = 1'b0;
    end
    mosi = ~mosi;
    #62.5 cs_n = 1'b1;
    #40;
  endtask
endmodule // spi_host

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic protect_regs_lock_bit = 1'b0;
  logic [15:0] sector_locked = 16'h0000;
  logic erase_verify_fail = 1'b0;
  logic spi_sck, cs_n, mosi, write_latch_flag, busy, erase_program_fail_flag, erase_start;
  logic [15:0] sector_protect_bit;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  spi_host host_u (.spi_sck, .cs_n, .mosi);
  flash_erase_protect_cmds #(.ERASE_CYCLES(20)) dut_u (.core_clk, .arst_n, .spi_sck, .cs_n, .mosi,
    .protect_regs_lock_bit, .sector_locked, .erase_verify_fail, .write_latch_flag, .busy,
    .erase_program_fail_flag, .erase_start, .sector_protect_bit);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic frame(input logic [39:0] d, input int n);
    host_u.send(d, n);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic wren();
    frame({flash_cmd_pkg::OP_WRITE_ENABLE, 32'h0}, 8);
  endtask
  task automatic t_latch();
    chk(sector_protect_bit, 16'hffff);
    frame(40'h0600000000, 7);
    chk(write_latch_flag, 1'b0);
    frame(40'h06a5000000, 16);
    chk(write_latch_flag, 1'b1);
    frame(40'h0400000000, 7);
    chk(write_latch_flag, 1'b1);
    frame(40'h0400000000, 8);
    chk(write_latch_flag, 1'b0);
    frame(40'hc700000000, 8);
    chk(busy, 1'b0);
  endtask
  task automatic t_unprot();
    for (int s = 0; s < 16; s++) begin
      wren();
      frame({flash_cmd_pkg::OP_UNPROTECT_SECTOR, 4'ha, s[3:0], 16'h1234, 8'h00}, 32);
      chk(sector_protect_bit, 16'(16'hfffe << s));
      chk(write_latch_flag, 1'b0);
    end
  endtask
  task automatic t_erase();
    for (int k = 0; k < 4; k++) begin
      sector_locked = (k == 0) ? 16'h0004 : 16'h0000;
      erase_verify_fail = (k == 3);
      wren();
      frame({k[0] ? 8'hc7 : 8'h60, 32'hffffffff}, (k == 1) ? 9 : 40);
      chk({busy, write_latch_flag}, {k > 1, 1'b0});
      for (int w = 0; w < 100 && busy !== 1'b0; w++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      #1;
      if (k > 1) chk(erase_program_fail_flag, k == 3);
    end
  endtask
  task automatic t_protect();
    wren();
    frame(40'h3605000000, 24);
    chk({sector_protect_bit, write_latch_flag}, 17'h0);
    wren();
    frame(40'h3605000080, 33);
    chk({sector_protect_bit, write_latch_flag}, 17'h0);
    wren();
    frame(40'h3605000000, 32);
    chk({sector_protect_bit, write_latch_flag}, 17'h00040);
    wren();
    frame(40'h3905000000, 31);
    chk({sector_protect_bit, write_latch_flag}, 17'h00040);
    protect_regs_lock_bit = 1'b1;
    wren();
    frame(40'h3905000000, 32);
    chk({sector_protect_bit, write_latch_flag}, 17'h00040);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 arst_n = 1'b1;
    @(posedge core_clk);
    #1;
    t_latch();
    t_unprot();
    t_erase();
    t_protect();
    end_sim();
  end
endmodule // tb_top
